// ### include/sensor_cfg_pkg.sv
// constants, types and address decoding shared by the configuration update block
package sensor_cfg_pkg;

    localparam int unsigned ADDR_W = 9;
    localparam int unsigned DATA_W = 16;

    // register word addresses
    localparam logic [8:0] ADDR_CLK_GEN      = 9'h020;
    localparam logic [8:0] ADDR_IMAGE_CORE   = 9'h028;
    localparam logic [8:0] ADDR_FRONT_END    = 9'h030;
    localparam logic [8:0] ADDR_BIAS_FIRST   = 9'h040;
    localparam logic [8:0] ADDR_BIAS_LAST    = 9'h047;
    localparam logic [8:0] ADDR_SERIAL_OUT   = 9'h070;
    localparam logic [8:0] ADDR_BLACK_A      = 9'h080;
    localparam logic [8:0] ADDR_BLACK_SYNC   = 9'h081;
    localparam logic [8:0] ADDR_SYNC_FIRST   = 9'h082;
    localparam logic [8:0] ADDR_SYNC_LAST    = 9'h087;
    localparam logic [8:0] ADDR_PATTERN_FIRST = 9'h090;
    localparam logic [8:0] ADDR_PATTERN_LAST = 9'h096;
    localparam logic [8:0] ADDR_SEQ_CTRL     = 9'h0C0;
    localparam logic [8:0] ADDR_ACTIVE_WIN   = 9'h0C3;
    localparam logic [8:0] ADDR_BLACK_LINES  = 9'h0C5;
    localparam logic [8:0] ADDR_DUMMY_LINES  = 9'h0C6;
    localparam logic [8:0] ADDR_EXPOSURE_FIRST = 9'h0C7;
    localparam logic [8:0] ADDR_EXPOSURE_LAST = 9'h0CB;
    localparam logic [8:0] ADDR_GAIN         = 9'h0CC;
    localparam logic [8:0] ADDR_SYNC_OPTIONS = 9'h0CE;

    // field positions
    localparam int unsigned SEQ_ENABLE_BIT    = 0;
    localparam int unsigned SEQ_MODE_LSB      = 1;
    localparam int unsigned SEQ_MODE_MSB      = 6;
    localparam int unsigned SEQ_SUBSAMPLE_BIT = 7;
    localparam int unsigned SEQ_BINNING_BIT   = 8;
    localparam int unsigned SEQ_EXP_SYNC_BIT  = 11;
    localparam int unsigned MODE_TRIGGERED_BIT = 0;
    localparam int unsigned MODE_SLAVE_BIT    = 1;
    localparam int unsigned MODE_ROLLING_BIT  = 3;
    localparam int unsigned BLACK_CAL_BIT     = 8;
    localparam int unsigned SYNC_CODE_EN_BIT  = 13;
    localparam int unsigned GAIN_LAT_COMP_BIT = 13;
    localparam int unsigned BLANK_ROI_SW_BIT  = 8;

    // reset values and counts
    localparam logic [15:0] REG_RESET_VALUE   = 16'h0000;
    localparam int unsigned EXPOSURE_REGS     = 5;
    localparam int unsigned BL_SETTLE_FRAMES  = 4;
    localparam int unsigned CYCLES_PER_LINE   = 64;
    localparam int unsigned LINES_PER_FRAME   = 32;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ARM  = 2'b01,
        SEQ_RUN  = 2'b11
    } seq_state_t;

    // registers that may only change while the sequencer is off
    function automatic logic isStatic(input logic [8:0] a);
        return a == ADDR_CLK_GEN || a == ADDR_IMAGE_CORE || a == ADDR_FRONT_END ||
               (a >= ADDR_BIAS_FIRST && a <= ADDR_BIAS_LAST) || a == ADDR_SERIAL_OUT;
    endfunction

    function automatic logic inRange(input logic [8:0] a, input logic [8:0] lo, input logic [8:0] hi);
        return a >= lo && a <= hi;
    endfunction

endpackage

// ### core/reg_store.sv
// host-visible register memory with registered read data
`timescale 1ns/100ps
module reg_store #(
    parameter int unsigned AW = 9,
    parameter int unsigned DW = 16
) (
    input  wire logic          sys_clk,
    input  wire logic          arst_n,
    input  wire logic          ce,
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrAddr,
    input  wire logic [DW-1:0] wrData,
    input  wire logic          rdEn,
    input  wire logic [AW-1:0] rdAddr,
    output logic      [DW-1:0] rdData
);
    import sensor_cfg_pkg::*;

    typedef struct packed {
        logic [DW-1:0] rdData;
    } store_state_t;

    logic [DW-1:0] mem [0:(1<<AW)-1];
    store_state_t  st;
    store_state_t  next_st;

    // array kept out of the reset struct so it maps onto block memory
    always_ff @(posedge sys_clk) begin
        if (ce && wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_comb begin
        next_st = st;
        if (ce && rdEn) begin
            next_st.rdData = mem[rdAddr];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdData = st.rdData;

endmodule // reg_store

// ### core/frame_timer.sv
// frame boundary generator for the running sequencer
`timescale 1ns/100ps
module frame_timer #(
    parameter int unsigned LINE_CYCLES = sensor_cfg_pkg::CYCLES_PER_LINE,
    parameter int unsigned FRAME_LINES = sensor_cfg_pkg::LINES_PER_FRAME
) (
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic ce,
    input  wire logic run,
    output logic      frameStart,
    output logic      inFrame
);
    import sensor_cfg_pkg::*;

    typedef struct packed {
        logic [15:0] cyc;
        logic [15:0] line;
        logic        frameStart;
        logic        inFrame;
    } timer_state_t;

    timer_state_t st;
    timer_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.frameStart = 1'b0;
        if (!run) begin
            next_st = '0;
        end else if (!st.inFrame) begin
            next_st.inFrame    = 1'b1;
            next_st.frameStart = 1'b1;
        end else if (st.cyc == 16'(LINE_CYCLES - 1)) begin
            next_st.cyc = '0;
            if (st.line == 16'(FRAME_LINES - 1)) begin
                // blanked frames run the same count, so the receiver stays aligned
                next_st.line       = '0;
                next_st.frameStart = 1'b1;
            end else begin
                next_st.line = st.line + 16'h0001;
            end
        end else begin
            next_st.cyc = st.cyc + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign frameStart = st.frameStart;
    assign inFrame    = st.inFrame;

endmodule // frame_timer

// ### core/sensor_config_update_control.sv
// configuration update control: shadow and active register sets, frame-synchronised loads
`timescale 1ns/100ps
module sensor_config_update_control #(
    parameter int unsigned LINE_CYCLES  = sensor_cfg_pkg::CYCLES_PER_LINE,
    parameter int unsigned FRAME_LINES  = sensor_cfg_pkg::LINES_PER_FRAME,
    parameter int unsigned SETTLE_COUNT = sensor_cfg_pkg::BL_SETTLE_FRAMES
) (
    input  wire logic                               sys_clk,
    input  wire logic                               arst_n,
    input  wire logic                               ce,
    input  wire logic                               regWrite,
    input  wire logic [sensor_cfg_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [sensor_cfg_pkg::DATA_W-1:0]  regWdata,
    input  wire logic                               regRead,
    output logic      [sensor_cfg_pkg::DATA_W-1:0]  regRdata,
    output logic                                    acquiring,
    output logic                                    frameStart,
    output logic                                    blankFrame,
    output logic                                    configCorrupt,
    output logic                                    blackLevelSettling,
    output logic                                    syncCodeSuspect,
    output logic                                    patternSuspect,
    output logic      [5:0]                         activeMode,
    output logic                                    activeSubsample,
    output logic                                    activeBinning,
    output logic      [15:0]                        activeWindows,
    output logic      [15:0]                        activeBlackLines,
    output logic      [15:0]                        activeDummyLines,
    output logic      [sensor_cfg_pkg::EXPOSURE_REGS*16-1:0] activeExposure,
    output logic      [15:0]                        activeGain
);
    import sensor_cfg_pkg::*;

    typedef struct packed {
        seq_state_t                        state;
        logic [15:0]                       seqShadow;
        logic [15:0]                       winShadow;
        logic [15:0]                       blkShadow;
        logic [15:0]                       dumShadow;
        logic [15:0]                       gainShadow;
        logic [15:0]                       optShadow;
        logic [EXPOSURE_REGS-1:0][15:0]    expShadow;
        logic [EXPOSURE_REGS-1:0][15:0]    expStage;
        logic [EXPOSURE_REGS-1:0][15:0]    expActive;
        logic [15:0]                       gainStage;
        logic [15:0]                       gainActive;
        logic [5:0]                        mode;
        logic                              sub;
        logic                              bin;
        logic [15:0]                       win;
        logic [15:0]                       blk;
        logic [15:0]                       dum;
        logic                              blankPending;
        logic                              blank;
        logic [3:0]                        settle;
        logic                              syncSuspect;
        logic                              patSuspect;
        logic                              corrupt;
    } ctrl_state_t;

    ctrl_state_t st;
    ctrl_state_t next_st;
    logic        timerStart;
    logic        timerInFrame;
    logic        running;
    logic        wr;
    logic        rolling;
    logic        expBypass;

    reg_store #(
        .AW (ADDR_W),
        .DW (DATA_W)
    ) u_store (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .wrEn    (regWrite),
        .wrAddr  (regAddr),
        .wrData  (regWdata),
        .rdEn    (regRead),
        .rdAddr  (regAddr),
        .rdData  (regRdata)
    );

    frame_timer #(
        .LINE_CYCLES (LINE_CYCLES),
        .FRAME_LINES (FRAME_LINES)
    ) u_timer (
        .sys_clk    (sys_clk),
        .arst_n     (arst_n),
        .ce         (ce),
        .run        (running),
        .frameStart (timerStart),
        .inFrame    (timerInFrame)
    );

    assign running = st.state == SEQ_RUN;
    assign wr      = regWrite;
    // shutter mode is latched at enable, so a mid-run mode write cannot flip it
    assign rolling = st.mode[MODE_ROLLING_BIT];
    assign expBypass = st.seqShadow[SEQ_EXP_SYNC_BIT] && st.mode[MODE_TRIGGERED_BIT] &&
                       !st.mode[MODE_SLAVE_BIT] && !rolling;

    always_comb begin
        next_st = st;

        // host writes land in the shadow copies
        if (wr) begin
            case (regAddr)
                ADDR_SEQ_CTRL:     next_st.seqShadow  = regWdata;
                ADDR_ACTIVE_WIN:   next_st.winShadow  = regWdata;
                ADDR_BLACK_LINES:  next_st.blkShadow  = regWdata;
                ADDR_DUMMY_LINES:  next_st.dumShadow  = regWdata;
                ADDR_GAIN:         next_st.gainShadow = regWdata;
                ADDR_SYNC_OPTIONS: next_st.optShadow  = regWdata;
                default: begin
                    if (inRange(regAddr, ADDR_EXPOSURE_FIRST, ADDR_EXPOSURE_LAST)) begin
                        next_st.expShadow[3'(regAddr - ADDR_EXPOSURE_FIRST)] = regWdata;
                    end
                end
            endcase
        end

        // sequencer state follows the enable bit
        case (st.state)
            SEQ_IDLE: begin
                if (st.seqShadow[SEQ_ENABLE_BIT]) begin
                    next_st.state = SEQ_ARM;
                end
            end
            SEQ_ARM: begin
                // first frame takes the whole shadow set, pipelines pre-filled
                next_st.mode       = st.seqShadow[SEQ_MODE_MSB:SEQ_MODE_LSB];
                next_st.sub        = st.seqShadow[SEQ_SUBSAMPLE_BIT];
                next_st.bin        = st.seqShadow[SEQ_BINNING_BIT];
                next_st.win        = st.winShadow;
                next_st.blk        = st.blkShadow;
                next_st.dum        = st.dumShadow;
                next_st.expStage   = st.expShadow;
                next_st.expActive  = st.expShadow;
                next_st.gainStage  = st.gainShadow;
                next_st.gainActive = st.gainShadow;
                next_st.state      = st.seqShadow[SEQ_ENABLE_BIT] ? SEQ_RUN : SEQ_IDLE;
            end
            SEQ_RUN: begin
                if (!st.seqShadow[SEQ_ENABLE_BIT]) begin
                    next_st.state        = SEQ_IDLE;
                    next_st.blankPending = 1'b0;
                    next_st.blank        = 1'b0;
                    next_st.settle       = '0;
                    next_st.syncSuspect  = 1'b0;
                    next_st.patSuspect   = 1'b0;
                    next_st.corrupt      = 1'b0;
                end
            end
            default: begin
                next_st.state = SEQ_IDLE;
            end
        endcase

        if (running && st.seqShadow[SEQ_ENABLE_BIT]) begin
            if (timerStart) begin
                // frame parameters switch only at the boundary
                // subsampling and binning follow the shadow here
                next_st.sub   = st.seqShadow[SEQ_SUBSAMPLE_BIT];
                next_st.bin   = st.seqShadow[SEQ_BINNING_BIT];
                next_st.win   = st.winShadow;
                next_st.blk   = st.blkShadow;
                next_st.dum   = st.dumShadow;
                // blank the settling frame, training patterns in its place
                next_st.blank = st.blankPending;
                next_st.blankPending = 1'b0;
                // exposure pipeline, one frame late unless bypassed
                next_st.expStage  = st.expShadow;
                next_st.expActive = expBypass ? st.expShadow : st.expStage;
                // gain at frame start, extra stage under compensation
                next_st.gainStage  = st.gainShadow;
                next_st.gainActive = st.gainShadow[GAIN_LAT_COMP_BIT] ? st.gainStage : st.gainShadow;
                // settle window counts down per frame
                if (st.settle != 4'h0) begin
                    next_st.settle = st.settle - 4'h1;
                end
                // sync-code doubt ends with its frame
                next_st.syncSuspect = 1'b0;
                // pattern doubt lasts one transient frame
                next_st.patSuspect = 1'b0;
                // corruption flag clears once a clean frame begins
                next_st.corrupt = 1'b0;
            end

            if (wr) begin
                // line-count change blanks one frame in rolling shutter only
                if (rolling && ((regAddr == ADDR_BLACK_LINES && regWdata != st.blkShadow) ||
                                (regAddr == ADDR_DUMMY_LINES && regWdata != st.dumShadow))) begin
                    next_st.blankPending = 1'b1;
                end
                // window switch blanks one frame when enabled
                // only the select register counts, resizes do not
                if (rolling && st.optShadow[BLANK_ROI_SW_BIT] &&
                    regAddr == ADDR_ACTIVE_WIN && regWdata != st.winShadow) begin
                    next_st.blankPending = 1'b1;
                end
                // black-level change opens a settle window
                if (inRange(regAddr, ADDR_BLACK_A, ADDR_BLACK_SYNC) ||
                    (regAddr == ADDR_BLACK_LINES &&
                     regWdata[BLACK_CAL_BIT] != st.blkShadow[BLACK_CAL_BIT])) begin
                    next_st.settle = 4'(SETTLE_COUNT);
                end
                // sync-code write marks the current frame
                if (regAddr == ADDR_BLACK_SYNC || inRange(regAddr, ADDR_SYNC_FIRST, ADDR_SYNC_LAST)) begin
                    next_st.syncSuspect = 1'b1;
                end
                // test-pattern write marks a transient frame
                if (inRange(regAddr, ADDR_PATTERN_FIRST, ADDR_PATTERN_LAST)) begin
                    next_st.patSuspect = 1'b1;
                end
                // static write during acquisition is flagged, never halts
                if (isStatic(regAddr) || (regAddr == ADDR_SEQ_CTRL &&
                    regWdata[SEQ_MODE_MSB:SEQ_MODE_LSB] != st.seqShadow[SEQ_MODE_MSB:SEQ_MODE_LSB])) begin
                    next_st.corrupt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign acquiring          = running;
    assign frameStart         = timerStart;
    assign blankFrame         = st.blank && timerInFrame;
    assign configCorrupt      = st.corrupt;
    assign blackLevelSettling = st.settle != 4'h0;
    assign syncCodeSuspect    = st.syncSuspect;
    assign patternSuspect     = st.patSuspect;
    assign activeMode         = st.mode;
    assign activeSubsample    = st.sub;
    assign activeBinning      = st.bin;
    assign activeWindows      = st.win;
    assign activeBlackLines   = st.blk;
    assign activeDummyLines   = st.dum;
    assign activeExposure     = st.expActive;
    assign activeGain         = st.gainActive;

endmodule // sensor_config_update_control

// ### sim/sensor_cfg_checker.sv
// port assertions for the configuration update block
`timescale 1ns/100ps
module sensor_cfg_checker
    import sensor_cfg_pkg::*;
#(
    parameter int unsigned LINE_CYCLES = sensor_cfg_pkg::CYCLES_PER_LINE,
    parameter int unsigned FRAME_LINES = sensor_cfg_pkg::LINES_PER_FRAME
) (
    input wire logic                              sys_clk,
    input wire logic                              arst_n,
    input wire logic                              regWrite,
    input wire logic [sensor_cfg_pkg::ADDR_W-1:0] regAddr,
    input wire logic [sensor_cfg_pkg::DATA_W-1:0] regWdata,
    input wire logic                              acquiring,
    input wire logic                              frameStart,
    input wire logic                              blankFrame,
    input wire logic                              configCorrupt,
    input wire logic                              blackLevelSettling,
    input wire logic                              syncCodeSuspect,
    input wire logic [5:0]                        activeMode,
    input wire logic [15:0]                       activeWindows,
    input wire logic [15:0]                       activeGain
);
    import sensor_cfg_pkg::*;
    // repetition counts below assume the bench frame of 8 cycles
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    property p_start; regWrite && regAddr == ADDR_SEQ_CTRL && regWdata[0] && !acquiring |-> ##[2:4] acquiring; endproperty
    a_start: assert property (p_start) else $error("sequencer did not start");
    property p_stop; regWrite && regAddr == ADDR_SEQ_CTRL && !regWdata[0] |-> ##[1:4] !acquiring; endproperty
    a_stop: assert property (p_stop) else $error("sequencer did not stop");
    property p_period; frameStart ##1 acquiring [*8] |-> frameStart; endproperty
    a_period: assert property (p_period) else $error("frame period broken");
    property p_blank_global; blankFrame |-> activeMode[MODE_ROLLING_BIT]; endproperty
    a_blank_global: assert property (p_blank_global) else $error("blank in global shutter");
    property p_blank_start; $rose(blankFrame) |-> $past(frameStart); endproperty
    a_blank_start: assert property (p_blank_start) else $error("blank off frame boundary");
    property p_blank_len; $rose(blankFrame) |-> blankFrame [*8] ##1 !blankFrame; endproperty
    a_blank_len: assert property (p_blank_len) else $error("blank not one frame");
    property p_gain_sync; acquiring && $past(acquiring) && !$stable(activeGain) |-> $past(frameStart); endproperty
    a_gain_sync: assert property (p_gain_sync) else $error("gain changed mid frame");
    property p_win_sync; acquiring && $past(acquiring) && !$stable(activeWindows) |-> $past(frameStart); endproperty
    a_win_sync: assert property (p_win_sync) else $error("window changed mid frame");
    property p_mode_held; acquiring && $past(acquiring) |-> $stable(activeMode); endproperty
    a_mode_held: assert property (p_mode_held) else $error("mode changed while running");
    property p_corrupt; regWrite && acquiring && regAddr == ADDR_CLK_GEN |=> configCorrupt && acquiring; endproperty
    a_corrupt: assert property (p_corrupt) else $error("static write not flagged");
    property p_settle; regWrite && acquiring && regAddr == ADDR_BLACK_A |=> blackLevelSettling && acquiring; endproperty
    a_settle: assert property (p_settle) else $error("black level settle missing");
    property p_sync; regWrite && acquiring && regAddr == ADDR_SYNC_FIRST |=> syncCodeSuspect; endproperty
    a_sync: assert property (p_sync) else $error("sync code flag missing");
    property p_sync_clr; frameStart && !regWrite |=> !syncCodeSuspect; endproperty
    a_sync_clr: assert property (p_sync_clr) else $error("sync code flag outlived frame");
endmodule // sensor_cfg_checker

bind sensor_config_update_control sensor_cfg_checker #(.LINE_CYCLES(LINE_CYCLES), .FRAME_LINES(FRAME_LINES)) chk (
    .sys_clk(sys_clk), .arst_n(arst_n), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
    .acquiring(acquiring), .frameStart(frameStart), .blankFrame(blankFrame), .configCorrupt(configCorrupt),
    .blackLevelSettling(blackLevelSettling), .syncCodeSuspect(syncCodeSuspect), .activeMode(activeMode),
    .activeWindows(activeWindows), .activeGain(activeGain));

// ### sim/host_model.sv
// host model driving the register write and read strobes
`timescale 1ns/100ps
module host_model
    import sensor_cfg_pkg::*;
(
    input  wire logic                              sys_clk,
    input  wire logic [sensor_cfg_pkg::DATA_W-1:0] regRdata,
    output logic                                   regWrite,
    output logic                                   regRead,
    output logic      [sensor_cfg_pkg::ADDR_W-1:0] regAddr,
    output logic      [sensor_cfg_pkg::DATA_W-1:0] regWdata
);
    import sensor_cfg_pkg::*;
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 9'h000;
        regWdata = 16'h0000;
    end
    // callers touch static, reserved and mode words only when idle, bar deliberate cases
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        regWrite = 1'b1; regAddr = a; regWdata = d;
        @(negedge sys_clk);
        // idle bus inverted so stale values fail
        regWrite = 1'b0; regAddr = ~a; regWdata = ~d;
    endtask
    task automatic rd(input logic [8:0] a, output logic [15:0] d);
        @(negedge sys_clk);
        regRead = 1'b1; regAddr = a;
        @(negedge sys_clk);
        regRead = 1'b0; regAddr = ~a;
        d = regRdata;
    endtask
endmodule // host_model

// ### sim/tb_sensor_config_update_control.sv
// self-checking bench for the configuration update block
`timescale 1ns/100ps
module tb_sensor_config_update_control;
    import sensor_cfg_pkg::*;
    logic                       sys_clk, arst_n, ce, regWrite, regRead, acquiring, frameStart, blankFrame;
    logic                       configCorrupt, blackLevelSettling, syncCodeSuspect, patternSuspect;
    logic                       activeSubsample, activeBinning;
    logic [8:0]                 regAddr;
    logic [5:0]                 activeMode;
    logic [15:0]                regWdata, regRdata, activeWindows, activeBlackLines, activeDummyLines, activeGain;
    logic [EXPOSURE_REGS*16-1:0] activeExposure;
    logic [15:0]                d, g, e;
    integer                     err_count = 0, checked = 0, seed = 32'h5B93;

    sensor_config_update_control #(.LINE_CYCLES(4), .FRAME_LINES(2)) uut (
        .sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .regWrite(regWrite), .regAddr(regAddr),
        .regWdata(regWdata), .regRead(regRead), .regRdata(regRdata), .acquiring(acquiring),
        .frameStart(frameStart), .blankFrame(blankFrame), .configCorrupt(configCorrupt),
        .blackLevelSettling(blackLevelSettling), .syncCodeSuspect(syncCodeSuspect),
        .patternSuspect(patternSuspect), .activeMode(activeMode), .activeSubsample(activeSubsample),
        .activeBinning(activeBinning), .activeWindows(activeWindows), .activeBlackLines(activeBlackLines),
        .activeDummyLines(activeDummyLines), .activeExposure(activeExposure), .activeGain(activeGain));
    host_model host (.sys_clk(sys_clk), .regRdata(regRdata), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [15:0] s, input logic [15:0] x);
        checked++;
        if (s !== x) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, x);
        end
    endtask
    // wait for frame start, then one load cycle
    task automatic frm;
        int n;
        n = 0;
        while (frameStart !== 1'b1 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 40) err_count++;
        @(negedge sys_clk);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        $display("watchdog expired at %0t", $time);
        err_count++;
        print_verdict;
    end

    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        repeat (20) @(negedge sys_clk);
        chk(acquiring, 16'h0000);
        arst_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            d = 16'($random(seed));
            host.wr(ADDR_BIAS_FIRST + 9'(i), d);
            host.rd(ADDR_BIAS_FIRST + 9'(i), g);
            chk(g, d);
        end
        $display("done: idle readback");
        host.wr(ADDR_GAIN, 16'h0005);
        host.wr(ADDR_EXPOSURE_FIRST, 16'h0010);
        host.wr(ADDR_SEQ_CTRL, 16'h0001);
        frm;
        chk(acquiring, 16'h0001);
        chk(activeGain, 16'h0005);
        g = 16'($random(seed));
        g[13] = 1'b0;
        host.wr(ADDR_GAIN, g);
        chk(activeGain, 16'h0005);
        frm;
        chk(activeGain, g);
        e = g;
        g = 16'($random(seed));
        g[13] = 1'b1;
        d = 16'($random(seed));
        host.wr(ADDR_GAIN, g);
        host.wr(ADDR_EXPOSURE_FIRST, d);
        frm;
        chk(activeGain, e);
        chk(activeExposure[15:0], 16'h0010);
        frm;
        chk(activeGain, g);
        chk(activeExposure[15:0], d);
        host.wr(ADDR_BLACK_LINES, 16'h0007);
        frm;
        chk(blankFrame, 16'h0000);
        chk(activeBlackLines, 16'h0007);
        $display("done: global latencies");
        host.wr(ADDR_CLK_GEN, 16'($random(seed)));
        chk(configCorrupt, 16'h0001);
        host.wr(ADDR_PATTERN_FIRST, 16'($random(seed)));
        host.wr(ADDR_SYNC_FIRST, 16'($random(seed)));
        chk(patternSuspect, 16'h0001);
        frm;
        chk(configCorrupt, 16'h0000);
        chk(patternSuspect, 16'h0000);
        host.wr(ADDR_BLACK_A, 16'($random(seed)));
        repeat (3) frm;
        chk(blackLevelSettling, 16'h0001);
        frm;
        chk(blackLevelSettling, 16'h0000);
        chk(acquiring, 16'h0001);
        host.wr(ADDR_SEQ_CTRL, 16'h0000);
        repeat (4) @(negedge sys_clk);
        chk(acquiring, 16'h0000);
        $display("done: dynamic flags");
        host.wr(ADDR_SEQ_CTRL, 16'h0011);
        frm;
        host.wr(ADDR_DUMMY_LINES, 16'h0003);
        frm;
        chk(blankFrame, 16'h0001);
        chk(activeDummyLines, 16'h0003);
        frm;
        chk(blankFrame, 16'h0000);
        host.wr(ADDR_SYNC_OPTIONS, 16'h0100);
        host.wr(ADDR_ACTIVE_WIN, 16'h0002);
        frm;
        chk(blankFrame, 16'h0001);
        host.wr(9'h100, 16'($random(seed)));
        host.wr(ADDR_ACTIVE_WIN, 16'h0002);
        frm;
        chk(blankFrame, 16'h0000);
        host.wr(ADDR_SEQ_CTRL, 16'h0191);
        chk({activeBinning, activeSubsample}, 16'h0000);
        frm;
        chk({activeBinning, activeSubsample}, 16'h0003);
        host.wr(ADDR_SEQ_CTRL, 16'h0000);
        repeat (4) @(negedge sys_clk);
        $display("done: rolling blanking");
        host.wr(ADDR_SEQ_CTRL, 16'h0803);
        frm;
        d = 16'($random(seed));
        host.wr(ADDR_EXPOSURE_FIRST, d);
        frm;
        chk(activeExposure[15:0], d);
        host.wr(ADDR_SEQ_CTRL, 16'h0000);
        $display("done: triggered exposure");
        print_verdict;
    end
endmodule // tb_sensor_config_update_control
